//--- pkg/can_front_pkg.sv
/*
 * Constants, frame record and state types for the CAN queue front end.
 * Assumes a 32-bit APB master with an 8-bit byte address.
 */
package can_front_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_FEATURE = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_COMMAND = 8'h08;

    // capability bits in the feature register
    localparam int FEAT_CLASSIC = 0;
    localparam int FEAT_FD      = 1;
    localparam int FEAT_REMOTE  = 2;
    localparam int FEAT_LATE    = 3;
    localparam logic [3:0] FEAT_RESET = 4'h1;

    // status and command register fields
    localparam int STAT_BUS_OFF = 0;
    localparam int STAT_STARTED = 1;
    localparam int CMD_BUSY     = 8;
    localparam logic [7:0] CMD_START = 8'h01;
    localparam logic [7:0] CMD_STOP  = 8'h02;

    localparam logic [7:0] RESULT_SUCCESS = 8'h00;
    localparam logic [7:0] RESULT_FAILURE = 8'h01;

    // record kinds and frame flags
    localparam logic [15:0] TX_KIND    = 16'h0001;
    localparam logic [15:0] RX_KIND    = 16'h0101;
    localparam logic [31:0] FD_FLAG    = 32'h0000_4000;
    localparam logic [31:0] EXT_FLAG   = 32'h0000_8000;
    localparam logic [31:0] REMOTE_FLAG = 32'h0000_2000;
    localparam logic [31:0] KNOWN_FLAGS = 32'h0000_E000;
    localparam logic [11:0] CLASSIC_MAX = 12'h008;
    localparam logic [11:0] FD_MAX      = 12'h040;

    typedef struct packed {
        logic [15:0] kind;
        logic [11:0] length;
        logic [31:0] flags;
        logic [31:0] ident;
    } frame_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT} tx_state_t;

    typedef struct packed {
        logic [3:0] feat;
        logic       bus_off;
        logic       started;
        logic       mode_req;
        logic       cmd_busy;
        logic [7:0] cmd_result;
        tx_state_t  tx_st;
        frame_t     tx_frame;
        logic       tx_done;
        logic [7:0] tx_result;
        logic       rx_valid;
        frame_t     rx_frame;
    } state_t;
endpackage

//--- logic/can_front_end.sv
/*
 * Queue-side front end of a CAN controller: transmit checks and results,
 * receive records, start/stop commands and bus-off status over APB.
 * Assumes the controller core reports its mode, accepts, acks and
 * bus-off on synchronous inputs, and the queues use valid/ready.
 */
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps

module can_front_end (
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // register bus
    input  wire can_front_pkg::apb_req_t apb_req,
    output      can_front_pkg::apb_rsp_t apb_rsp,
    // transmit queue
    input  wire logic                    tx_req_valid,
    input  wire can_front_pkg::frame_t   tx_req,
    output      logic                    tx_req_ready,
    output      logic                    tx_done,
    output      logic [7:0]              tx_result,
    // receive queue
    input  wire logic                    rx_buf_avail,
    output      logic                    rx_rec_valid,
    output      can_front_pkg::frame_t   rx_rec,
    // controller mode
    output      logic                    ctrl_run_req,
    input  wire logic                    ctrl_running,
    input  wire logic                    ctrl_fault,
    input  wire logic                    can_bus_off,
    // controller transmit
    output      logic                    can_tx_valid,
    output      can_front_pkg::frame_t   can_tx_frame,
    input  wire logic                    can_tx_accept,
    input  wire logic                    can_tx_ack,
    output      logic                    can_tx_abort,
    // controller receive
    input  wire logic                    can_rx_valid,
    input  wire can_front_pkg::frame_t   can_rx_frame,
    output      logic                    can_rx_ready
);
    import can_front_pkg::*;

    state_t      s_reg;
    state_t      s_next;
    logic        apb_access;
    logic        apb_done;
    logic        cmd_stall;
    logic        addr_ok;
    logic        feat_ok;
    logic        bad_write;
    logic        tx_fd;
    logic        tx_ext;
    logic        tx_remote;
    logic [11:0] tx_max;
    logic        tx_type_ok;
    logic        tx_range_ok;
    logic        tx_ok;
    logic [11:0] rx_max;
    logic        rx_take;
    logic [31:0] rd_data;

    ////////////////////////////////////////////////////////////////////
    // register bus decode

    assign apb_access = apb_req.psel && apb_req.penable;
    assign addr_ok = (apb_req.paddr == ADDR_FEATURE) || (apb_req.paddr == ADDR_STATUS)
                     || (apb_req.paddr == ADDR_COMMAND);
    // refuse a capability set without classic or FD
    assign feat_ok = (apb_req.pwdata[FEAT_CLASSIC] || apb_req.pwdata[FEAT_FD])
                     && !(apb_req.pwdata[FEAT_REMOTE] && !apb_req.pwdata[FEAT_CLASSIC]);
    // capabilities change only while stopped
    assign bad_write = apb_req.pwrite && (((apb_req.paddr == ADDR_FEATURE)
                       && (!feat_ok || s_reg.started)) || (apb_req.paddr == ADDR_STATUS));
    // a second command waits until the first has finished
    assign cmd_stall = apb_req.pwrite && (apb_req.paddr == ADDR_COMMAND) && s_reg.cmd_busy;
    assign apb_done = apb_access && !cmd_stall;

    always_comb begin
        rd_data = '0;
        case (apb_req.paddr)
            ADDR_FEATURE: rd_data[3:0] = s_reg.feat;
            ADDR_STATUS: begin
                rd_data[STAT_BUS_OFF] = s_reg.bus_off;
                rd_data[STAT_STARTED] = s_reg.started;
            end
            ADDR_COMMAND: begin
                rd_data[7:0] = s_reg.cmd_result;
                rd_data[CMD_BUSY] = s_reg.cmd_busy;
            end
            default: rd_data = '0;
        endcase
    end

    assign apb_rsp.pready  = !cmd_stall;
    assign apb_rsp.pslverr = apb_done && (!addr_ok || bad_write);
    assign apb_rsp.prdata  = (apb_done && !apb_req.pwrite) ? rd_data : '0;

    ////////////////////////////////////////////////////////////////////
    // transmit record checks

    // flags word selects the frame kind
    assign tx_fd     = |(tx_req.flags & FD_FLAG);
    assign tx_ext    = |(tx_req.flags & EXT_FLAG);
    assign tx_remote = |(tx_req.flags & REMOTE_FLAG);
    assign tx_max = tx_fd ? FD_MAX : CLASSIC_MAX;
    // unnegotiated kinds and unknown flags fail
    assign tx_type_ok = ((tx_req.flags & ~KNOWN_FLAGS) == '0)
                        && (tx_fd ? s_reg.feat[FEAT_FD] : s_reg.feat[FEAT_CLASSIC])
                        && !(tx_remote && (tx_fd || !s_reg.feat[FEAT_REMOTE]));
    assign tx_range_ok = (tx_req.ident[31:29] == '0)
                         && (tx_ext || (tx_req.ident[28:11] == '0))
                         && (tx_req.length <= tx_max);
    assign tx_ok = (tx_req.kind == TX_KIND) && tx_type_ok && tx_range_ok && s_reg.started;

    ////////////////////////////////////////////////////////////////////
    // receive path

    // payload bound follows the FD capability
    assign rx_max = s_reg.feat[FEAT_FD] ? FD_MAX : CLASSIC_MAX;
    // no buffering, so records leave in bus order
    assign can_rx_ready = rx_buf_avail;
    assign rx_take = can_rx_valid && rx_buf_avail;

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_next = s_reg;
        s_next.tx_done  = 1'b0;
        s_next.rx_valid = 1'b0;

        if (apb_done && apb_req.pwrite && !bad_write
            && (apb_req.paddr == ADDR_FEATURE)) begin
            s_next.feat = apb_req.pwdata[3:0];
        end

        // complete once the controller is in the mode
        if (s_reg.cmd_busy) begin
            if (ctrl_fault) begin
                s_next.cmd_busy   = 1'b0;
                s_next.cmd_result = RESULT_FAILURE;
                s_next.mode_req   = ctrl_running;
                s_next.started    = ctrl_running;
            end else if (ctrl_running == s_reg.mode_req) begin
                s_next.cmd_busy   = 1'b0;
                s_next.cmd_result = RESULT_SUCCESS;
                s_next.started    = s_reg.mode_req;
                if (s_reg.mode_req) begin
                    s_next.bus_off = 1'b0;
                end
            end
        end

        // command taken only when none is in flight
        if (apb_done && apb_req.pwrite && (apb_req.paddr == ADDR_COMMAND)) begin
            if ((apb_req.pwdata[7:0] == CMD_START) || (apb_req.pwdata[7:0] == CMD_STOP)) begin
                s_next.cmd_busy = 1'b1;
                s_next.mode_req = (apb_req.pwdata[7:0] == CMD_START);
            end else begin
                s_next.cmd_result = RESULT_FAILURE;
            end
        end

        // bus-off stops and flags, set wins over clear
        if (can_bus_off) begin
            s_next.bus_off  = 1'b1;
            s_next.started  = 1'b0;
            s_next.mode_req = 1'b0;
            if (s_reg.cmd_busy) begin
                s_next.cmd_busy   = 1'b0;
                s_next.cmd_result = RESULT_FAILURE;
            end
        end

        case (s_reg.tx_st)
            TX_IDLE: begin
                if (tx_req_valid) begin
                    s_next.tx_frame = tx_req;
                    s_next.tx_frame.ident[31:29] = '0;
                    if (tx_ok) begin
                        s_next.tx_st = TX_SEND;
                    end else begin
                        s_next.tx_done   = 1'b1;
                        s_next.tx_result = RESULT_FAILURE;
                    end
                end
            end
            TX_SEND: begin
                if (!s_reg.started) begin
                    s_next.tx_st     = TX_IDLE;
                    s_next.tx_done   = 1'b1;
                    s_next.tx_result = RESULT_FAILURE;
                end else if (can_tx_accept) begin
                    if (s_reg.feat[FEAT_LATE]) begin
                        s_next.tx_st = TX_WAIT;
                    end else begin
                        s_next.tx_st     = TX_IDLE;
                        s_next.tx_done   = 1'b1;
                        s_next.tx_result = RESULT_SUCCESS;
                    end
                end
            end
            TX_WAIT: begin
                if (!s_reg.started) begin
                    s_next.tx_st     = TX_IDLE;
                    s_next.tx_done   = 1'b1;
                    s_next.tx_result = RESULT_FAILURE;
                end else if (can_tx_ack) begin
                    s_next.tx_st     = TX_IDLE;
                    s_next.tx_done   = 1'b1;
                    s_next.tx_result = RESULT_SUCCESS;
                end
            end
            default: s_next.tx_st = TX_IDLE;
        endcase

        if (rx_take && s_reg.started && (can_rx_frame.length <= rx_max)) begin
            s_next.rx_valid          = 1'b1;
            s_next.rx_frame          = can_rx_frame;
            s_next.rx_frame.kind     = RX_KIND;
            s_next.rx_frame.flags    = can_rx_frame.flags & KNOWN_FLAGS;
            s_next.rx_frame.ident[31:29] = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg      <= '0;
            s_reg.feat <= FEAT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tx_req_ready = (s_reg.tx_st == TX_IDLE);
    assign tx_done      = s_reg.tx_done;
    assign tx_result    = s_reg.tx_result;
    assign rx_rec_valid = s_reg.rx_valid;
    assign rx_rec       = s_reg.rx_frame;
    assign ctrl_run_req = s_reg.mode_req;
    assign can_tx_valid = (s_reg.tx_st == TX_SEND) && s_reg.started;
    assign can_tx_frame = s_reg.tx_frame;
    assign can_tx_abort = (s_reg.tx_st != TX_IDLE) && !s_reg.started;

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_tx_taken_stopped;
        tx_req_valid && tx_req_ready && !s_reg.started;
    endsequence

    sequence s_fail_next;
        ##1 (tx_done && (tx_result == RESULT_FAILURE));
    endsequence

    sequence s_bus_off_waiting;
        can_bus_off && s_reg.started && (s_reg.tx_st != TX_IDLE) && !can_tx_accept && !can_tx_ack;
    endsequence

    a_tx_stopped_fail: assert property (@(posedge pclk) disable iff (!presetn)
        s_tx_taken_stopped |-> s_fail_next)
        else $error("transmit while stopped not failed");

    a_tx_kind_check: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_req_valid && tx_req_ready && (tx_req.kind != TX_KIND)) |-> s_fail_next)
        else $error("wrong record kind not refused");

    a_unknown_flag_reject: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_req_valid && tx_req_ready && ((tx_req.flags & ~KNOWN_FLAGS) != '0))
        |-> s_fail_next)
        else $error("undefined flag not refused");

    a_bus_off_cancel: assert property (@(posedge pclk) disable iff (!presetn)
        s_bus_off_waiting |-> ##1 !s_reg.started ##1 (tx_done && (tx_result == RESULT_FAILURE)))
        else $error("pending frame not failed after bus-off");

    a_late_ack_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_done && (tx_result == RESULT_SUCCESS) && s_reg.feat[FEAT_LATE])
        |-> $past(can_tx_ack))
        else $error("late success without bus ack");

    a_rx_record_shape: assert property (@(posedge pclk) disable iff (!presetn)
        rx_rec_valid |-> ((rx_rec.kind == RX_KIND) && (rx_rec.ident[31:29] == '0)
                          && (rx_rec.length <= FD_MAX)))
        else $error("bad receive record");

    a_start_status_first: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(s_reg.cmd_busy) && (s_reg.cmd_result == RESULT_SUCCESS))
        |-> (s_reg.started == s_reg.mode_req))
        else $error("status not updated with completion");

    a_cmd_in_order: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_access && apb_req.pwrite && (apb_req.paddr == ADDR_COMMAND) && s_reg.cmd_busy)
        |-> !apb_rsp.pready)
        else $error("command taken while another in flight");

    a_stopped_silent: assert property (@(posedge pclk) disable iff (!presetn)
        !s_reg.started |-> !can_tx_valid ##1 !rx_rec_valid)
        else $error("bus traffic while stopped");

    a_bus_off_flag: assert property (@(posedge pclk) disable iff (!presetn)
        can_bus_off |=> (s_reg.bus_off && !s_reg.started && !ctrl_run_req))
        else $error("bus-off not flagged");

    a_tx_long_reject: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_req_valid && tx_req_ready && (tx_req.length > FD_MAX)) |-> s_fail_next)
        else $error("overlong frame not refused");

    a_rx_long_drop: assert property (@(posedge pclk) disable iff (!presetn)
        (can_rx_valid && (can_rx_frame.length > FD_MAX)) |=> !rx_rec_valid)
        else $error("overlong receive frame kept");

endmodule

//--- bench/can_ctrl_model.sv
/*
 * Behavioural CAN controller core on the far side of the front end.
 * Assumes the front end's clock; mode and accept delays come from the bench.
 */
`timescale 1ns/100ps

module can_ctrl_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // delays chosen by the bench
    input  wire logic [3:0] mode_dly,
    input  wire logic [3:0] acc_dly,
    // mode
    input  wire logic       ctrl_run_req,
    input  wire logic       can_bus_off,
    output      logic       ctrl_running,
    // transmit
    input  wire logic       can_tx_valid,
    input  wire logic       can_tx_abort,
    output      logic       can_tx_accept,
    output      logic       can_tx_ack
);
    logic [3:0] mcnt;
    logic [3:0] tcnt;
    logic       held_off;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_running  <= 1'b0;
            can_tx_accept <= 1'b0;
            can_tx_ack    <= 1'b0;
            mcnt          <= 4'h0;
            tcnt          <= 4'h0;
            held_off      <= 1'b0;
        end else begin
            // bus-off holds the core until run drops
            if (can_bus_off) begin
                ctrl_running <= 1'b0;
                held_off     <= 1'b1;
            end else if (!ctrl_run_req) begin
                held_off <= 1'b0;
            end
            if (can_bus_off || (held_off && ctrl_run_req) || ctrl_running == ctrl_run_req) begin
                mcnt <= 4'h0;
            end else if (mcnt >= mode_dly) begin
                ctrl_running <= ctrl_run_req;
                mcnt         <= 4'h0;
            end else begin
                mcnt <= mcnt + 4'h1;
            end
            // schedule after a delay, ack a cycle later
            can_tx_accept <= 1'b0;
            can_tx_ack    <= can_tx_accept && ctrl_running;
            if (can_tx_valid && !can_tx_accept && !can_tx_abort && ctrl_running) begin
                if (tcnt >= acc_dly) begin
                    can_tx_accept <= 1'b1;
                    tcnt          <= 4'h0;
                end else begin
                    tcnt <= tcnt + 4'h1;
                end
            end else begin
                tcnt <= 4'h0;
            end
        end
    end
endmodule

//--- bench/tb_can_front_end.sv
/*
 * Self-checking bench: APB registers, transmit checks, receive records,
 * start, stop, fault and bus-off. Assumes the core model and a 40 MHz clock.
 */
`timescale 1ns/100ps

module tb_can_front_end;
    import can_front_pkg::*;

    logic       pclk, presetn, tx_req_valid, tx_req_ready, tx_done, rx_buf_avail;
    logic       rx_rec_valid, ctrl_run_req, ctrl_running, ctrl_fault, can_bus_off;
    logic       can_tx_valid, can_tx_accept, can_tx_ack, can_tx_abort, can_rx_valid;
    logic       can_rx_ready, started, acked;
    apb_req_t   apb_req;
    apb_rsp_t   apb_rsp;
    frame_t     tx_req, rx_rec, can_tx_frame, can_rx_frame, f, sent;
    logic [7:0] tx_result;
    logic [3:0] mode_dly, acc_dly, feat;
    logic [7:0] tx_q[$];
    frame_t     rx_q[$];
    logic [3:0] cfgs[5];
    int         fails, total_checks;

    can_front_end u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .tx_req_valid(tx_req_valid), .tx_req(tx_req), .tx_req_ready(tx_req_ready),
        .tx_done(tx_done), .tx_result(tx_result), .rx_buf_avail(rx_buf_avail),
        .rx_rec_valid(rx_rec_valid), .rx_rec(rx_rec), .ctrl_run_req(ctrl_run_req),
        .ctrl_running(ctrl_running), .ctrl_fault(ctrl_fault), .can_bus_off(can_bus_off),
        .can_tx_valid(can_tx_valid), .can_tx_frame(can_tx_frame), .can_tx_abort(can_tx_abort),
        .can_tx_accept(can_tx_accept), .can_tx_ack(can_tx_ack), .can_rx_valid(can_rx_valid),
        .can_rx_frame(can_rx_frame), .can_rx_ready(can_rx_ready));
    can_ctrl_model u_ctrl (.pclk(pclk), .presetn(presetn), .mode_dly(mode_dly),
        .acc_dly(acc_dly), .ctrl_run_req(ctrl_run_req), .can_bus_off(can_bus_off),
        .ctrl_running(ctrl_running), .can_tx_valid(can_tx_valid), .can_tx_abort(can_tx_abort),
        .can_tx_accept(can_tx_accept), .can_tx_ack(can_tx_ack));

    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(string nm, logic [95:0] seen, logic [95:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic limit(int n, int lim);
        if (n >= lim) begin
            check("wait_limit", 1'b1, 1'b0);
            finish_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic err, output logic [31:0] q);
        int n;
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 400);
        limit(n, 400);
        q = apb_rsp.prdata;
        check("pslverr", apb_rsp.pslverr, err);
        apb_req <= '0;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d, logic err);
        logic [31:0] q;
        apb(1'b1, a, d, err, q);
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, 1'b0, q);
        check("reg_read", q, exp);
    endtask

    // waits out a busy command, then compares its result
    task automatic cmd_wait(logic [7:0] res);
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            apb(1'b0, ADDR_COMMAND, 32'h0, 1'b0, q);
            n++;
        end while (q[CMD_BUSY] !== 1'b0 && n < 100);
        limit(n, 100);
        check("cmd_result", q[7:0], res);
    endtask

    task automatic cmd(logic [7:0] code, logic [7:0] res);
        wr(ADDR_COMMAND, {24'h0, code}, 1'b0);
        cmd_wait(res);
    endtask

    function automatic logic [7:0] tx_exp(logic [3:0] ft, frame_t x, logic run);
        logic fd;
        logic bad;
        fd  = x.flags[14];
        bad = !run || x.kind != TX_KIND || (x.flags & ~KNOWN_FLAGS) != 0 || x.ident[31:29] != 0
            || (fd ? !ft[FEAT_FD] : !ft[FEAT_CLASSIC]) || (x.flags[13] && (fd || !ft[FEAT_REMOTE]))
            || (!x.flags[15] && x.ident > 32'h0000_07FF) || x.length > (fd ? FD_MAX : CLASSIC_MAX);
        return bad ? RESULT_FAILURE : RESULT_SUCCESS;
    endfunction

    function automatic frame_t mk(int i);
        frame_t x;
        x = '{TX_KIND, 12'($urandom_range(8)), 32'h0, 32'($urandom_range(2047))};
        case (i)
            1: x = '{TX_KIND, 12'h008, EXT_FLAG, {3'b000, 29'($urandom)}};
            2: x = '{TX_KIND, FD_MAX, FD_FLAG, 32'h0000_07FF};
            3: x = '{TX_KIND, 12'h041, FD_FLAG | EXT_FLAG, 32'h0000_0001};
            4: x.flags = REMOTE_FLAG;
            5: x.flags = REMOTE_FLAG | FD_FLAG;
            6: x.flags = 32'h0000_1000;
            7: x.kind = 16'h0002;
            8: x = '{TX_KIND, 12'h000, EXT_FLAG, 32'h2000_0000};
            9: x.ident = 32'h0000_0800;
            10: x.length = 12'h009;
            11: x = '{TX_KIND, 12'h000, FD_FLAG | EXT_FLAG, 32'h1FFF_FFFF};
            default: ;
        endcase
        return x;
    endfunction

    task automatic send(frame_t x, logic [7:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (tx_req_ready !== 1'b1 && n < 300);
        limit(n, 300);
        sent = x;
        tx_q.push_back(exp);
        tx_req_valid <= 1'b1;
        tx_req       <= x;
        @(posedge pclk);
        tx_req_valid <= 1'b0;
    endtask

    // back-to-back frames from the core; overlong ones vanish
    task automatic rx_burst();
        frame_t x;
        for (int i = 0; i < 4; i++) begin
            x = '{16'($urandom), 12'($urandom_range(70)), $urandom & 32'h0000_F000, $urandom};
            if (started && x.length <= (feat[FEAT_FD] ? FD_MAX : CLASSIC_MAX))
                rx_q.push_back('{RX_KIND, x.length, x.flags & KNOWN_FLAGS, {3'b000, x.ident[28:0]}});
            can_rx_valid <= 1'b1;
            can_rx_frame <= x;
            @(posedge pclk);
        end
        can_rx_valid <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        if (tx_done === 1'b1) begin
            check("tx_result", tx_result, tx_q.size() ? tx_q.pop_front() : 8'hFF);
            if (feat[FEAT_LATE] && tx_result === RESULT_SUCCESS)
                check("late_ack", acked, 1'b1);
        end
        if (tx_req_valid && tx_req_ready) acked = 1'b0;
        if (can_tx_ack === 1'b1) acked = 1'b1;
        if (can_tx_accept === 1'b1) check("tx_frame", can_tx_frame, sent);
        if (rx_rec_valid === 1'b1)
            check("rx_rec", rx_rec, rx_q.size() ? rx_q.pop_front() : '1);
    end

    initial begin
        presetn = 1'b0;
        apb_req = '0;
        tx_req_valid = 1'b0;
        tx_req = '0;
        rx_buf_avail = 1'b1;
        ctrl_fault = 1'b0;
        can_bus_off = 1'b0;
        can_rx_valid = 1'b0;
        can_rx_frame = '0;
        mode_dly = 4'h2;
        acc_dly = 4'h1;
        feat = FEAT_RESET;
        started = 1'b0;
        acked = 1'b0;
        cfgs = '{4'h1, 4'h3, 4'h5, 4'h2, 4'hB};
        void'($urandom(79076));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_FEATURE, 32'h1);
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_COMMAND, 32'h0);
        check("run_req", ctrl_run_req, 1'b0);
        wr(8'h0C, 32'h0, 1'b1);
        wr(ADDR_STATUS, 32'h3, 1'b1);
        wr(ADDR_FEATURE, 32'h0, 1'b1);
        wr(ADDR_FEATURE, 32'h4, 1'b1);
        rd(ADDR_FEATURE, 32'h1);
        send(mk(0), RESULT_FAILURE);
        rx_burst();
        $display("test reset and stopped done");
        foreach (cfgs[k]) begin
            mode_dly <= 4'($urandom_range(6));
            acc_dly  <= 4'($urandom_range(3));
            cmd(CMD_STOP, RESULT_SUCCESS);
            started = 1'b0;
            wr(ADDR_FEATURE, {28'h0, cfgs[k]}, 1'b0);
            feat = cfgs[k];
            cmd(CMD_START, RESULT_SUCCESS);
            started = 1'b1;
            rd(ADDR_STATUS, 32'h2);
            for (int i = 0; i < 12; i++) begin
                f = mk(i);
                send(f, tx_exp(feat, f, 1'b1));
            end
            rx_burst();
            $display("test features %h done", cfgs[k]);
        end
        wr(ADDR_FEATURE, 32'h1, 1'b1);
        rx_buf_avail <= 1'b0;
        can_rx_valid <= 1'b1;
        @(posedge pclk);
        check("rx_ready", can_rx_ready, 1'b0);
        can_rx_valid <= 1'b0;
        rx_buf_avail <= 1'b1;
        mode_dly <= 4'h0;
        acc_dly  <= 4'hF;
        send(mk(0), RESULT_FAILURE);
        cmd(CMD_STOP, RESULT_SUCCESS);
        cmd(CMD_START, RESULT_SUCCESS);
        send(mk(0), RESULT_FAILURE);
        repeat (2) @(posedge pclk);
        can_bus_off <= 1'b1;
        @(posedge pclk);
        can_bus_off <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(ADDR_STATUS, 32'h1);
        cmd(CMD_START, RESULT_SUCCESS);
        rd(ADDR_STATUS, 32'h2);
        cmd(CMD_STOP, RESULT_SUCCESS);
        $display("test stop and bus-off done");
        mode_dly   <= 4'hF;
        ctrl_fault <= 1'b1;
        cmd(CMD_START, RESULT_FAILURE);
        ctrl_fault <= 1'b0;
        mode_dly   <= 4'h3;
        wr(ADDR_COMMAND, {24'h0, CMD_START}, 1'b0);
        wr(ADDR_COMMAND, {24'h0, CMD_STOP}, 1'b0);
        cmd_wait(RESULT_SUCCESS);
        cmd(8'h03, RESULT_FAILURE);
        rd(ADDR_STATUS, 32'h0);
        repeat (10) @(posedge pclk);
        check("tx_left", tx_q.size(), 0);
        check("rx_left", rx_q.size(), 0);
        $display("test fault and order done");
        finish_test();
    end
endmodule
